/* inc/psq_regs.svh */
// register addresses, field codes and reset values of the program sequencer
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH
// ****************************************
// phases and reset values
// ****************************************
`define PSQ_PH_T1 2'h0
`define PSQ_PH_T2 2'h1
`define PSQ_PH_T3 2'h2
`define PSQ_PH_T4 2'h3
`define PSQ_PC_RST 10'h000
`define PSQ_IRQ_VEC 10'h004
`define PSQ_LAST_PAGE 10'h300
`define PSQ_NOP 14'h0000
`define PSQ_STK_DEPTH 4
`define PSQ_STK_FULL 3'h4
// ****************************************
// internal register addresses
// ****************************************
`define PSQ_A_ACC 8'h05
`define PSQ_A_PCL 8'h06
`define PSQ_A_TBLP 8'h07
`define PSQ_A_TABLE_HIGH_BYTE 8'h08
`define PSQ_A_STATUS 8'h0A
// ****************************************
// status bits
// ****************************************
`define PSQ_F_C 0
`define PSQ_F_AC 1
`define PSQ_F_Z 2
`define PSQ_F_OV 3
// ****************************************
// instruction classes and codes
// ****************************************
`define PSQ_CL_MISC 2'h0
`define PSQ_CL_ALUA 2'h1
`define PSQ_CL_ALUM 2'h2
`define PSQ_CL_BR 2'h3
`define PSQ_MS_SYS 4'h0
`define PSQ_MS_TABC 4'h1
`define PSQ_MS_TABL 4'h2
`define PSQ_MS_MOVL 4'h3
`define PSQ_MS_MOVM 4'h4
`define PSQ_MS_SZ 4'h5
`define PSQ_MS_SNZ 4'h6
`define PSQ_MS_SIZ 4'h7
`define PSQ_MS_SDZ 4'h8
`define PSQ_SYS_RET 2'h1
`define PSQ_SYS_INTERRUPT_EXIT 2'h2
`define PSQ_DAA_LO 8'h06
`define PSQ_DAA_HI 9'h060
`define PSQ_BCD_MAX 4'h9
`endif

/* inc/psq_pkg.sv */
// types shared by the program sequencer files
package psq_pkg;
  typedef logic [13:0] psq_word_t;
  typedef logic [9:0] psq_addr_t;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
    ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_DAA, ALU_MOV
  } psq_alu_e;
  typedef enum logic {CYC_NORMAL, CYC_TABLE} psq_cyc_e;
endpackage

/* src/psq_return_stack.sv */
// four-level return address stack
`timescale 1ns/10ps
`include "psq_regs.svh"
module psq_return_stack
  import psq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire psq_addr_t push_data_i,
  output psq_addr_t top_data_o,
  output logic full_o
);
  psq_addr_t mem [0:`PSQ_STK_DEPTH-1];
  logic [1:0] sp_reg;
  logic [2:0] cnt_reg;

  assign top_data_o = mem[sp_reg - 2'h1];
  assign full_o = cnt_reg == `PSQ_STK_FULL;

  // pointer wraps on overflow, older entry lost
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sp_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end else if (push_i) begin
      sp_reg <= sp_reg + 2'h1;
      cnt_reg <= full_o ? cnt_reg : cnt_reg + 3'h1;
    end else if (pop_i) begin
      sp_reg <= sp_reg - 2'h1;
      cnt_reg <= (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push_i) begin
      mem[sp_reg] <= push_data_i;
    end
  end
endmodule

/* src/psq_sequencer.sv */
// four-phase fetch/execute sequencer with alu, table reads and return stack
`timescale 1ns/10ps
`include "psq_regs.svh"
module psq_sequencer
  import psq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  output psq_addr_t pmem_addr_o,
  input wire psq_word_t pmem_data_i,
  output logic [7:0] dmem_addr_o,
  output logic [7:0] dmem_wdata_o,
  output logic dmem_we_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic irq_i,
  input wire logic int_enable_i,
  output logic int_ack_o,
  output logic [3:0] instruction_phase_clocks_o,
  output psq_addr_t pc_o,
  output logic [7:0] acc_o,
  output logic [3:0] status_o,
  output logic [5:0] table_high_byte_o,
  output logic stack_full_o
);
  // ****************************************
  // state
  // ****************************************
  logic [1:0] ph_reg;
  psq_addr_t pc_reg, pc_next, tbla_reg, tbla_next;
  psq_word_t ir_reg, ir_next, fet_reg, tbl_reg;
  psq_cyc_e cyc_reg, cyc_next;
  logic [7:0] acc_reg, opnd_reg, res_reg, res_next, tblp_reg;
  logic [3:0] st_reg, nfl_reg, nfl_next;
  logic [5:0] table_high_byte_reg;
  logic skip_reg, skip_next, pend_reg, insvc_reg, ack_reg;

  // ****************************************
  // decode
  // ****************************************
  wire [1:0] cls = ir_reg[13:12];
  // misc sub-code sits below the class bits so all nine codes are reachable
  wire [3:0] misc = ir_reg[11:8];
  wire [7:0] maddr = ir_reg[7:0];
  wire cyc_tab = cyc_reg == CYC_TABLE;
  wire is_misc = cls == `PSQ_CL_MISC;
  wire is_alu = (cls == `PSQ_CL_ALUA) || (cls == `PSQ_CL_ALUM);
  wire is_br = ~cyc_tab & (cls == `PSQ_CL_BR);
  wire is_call = is_br & ir_reg[10];
  wire is_sys = is_misc & (misc == `PSQ_MS_SYS);
  wire is_ret = ~cyc_tab & is_sys & (ir_reg[1:0] == `PSQ_SYS_RET);
  wire is_interrupt_exit = ~cyc_tab & is_sys & (ir_reg[1:0] == `PSQ_SYS_INTERRUPT_EXIT);
  wire is_tabc = is_misc & (misc == `PSQ_MS_TABC);
  wire is_tabl = is_misc & (misc == `PSQ_MS_TABL);
  wire is_tab = ~cyc_tab & (is_tabc | is_tabl);
  wire is_movl = is_misc & (misc == `PSQ_MS_MOVL);
  wire is_movm = is_misc & (misc == `PSQ_MS_MOVM);
  wire is_snz = is_misc & (misc == `PSQ_MS_SNZ);
  wire is_siz = is_misc & (misc == `PSQ_MS_SIZ);
  wire is_sdz = is_misc & (misc == `PSQ_MS_SDZ);
  wire is_skip = is_misc & ((misc == `PSQ_MS_SZ) | is_snz | is_siz | is_sdz);
  wire wr_acc = ~cyc_tab & ((cls == `PSQ_CL_ALUA) | is_movl);
  wire wr_mem = cyc_tab | ((cls == `PSQ_CL_ALUM) | is_movm | is_siz | is_sdz);
  wire at_t4 = ph_reg == `PSQ_PH_T4;

  // ****************************************
  // operand read, internal registers first
  // ****************************************
  wire [7:0] rd_data =
    (maddr == `PSQ_A_ACC) ? acc_reg :
    (maddr == `PSQ_A_PCL) ? pc_reg[7:0] :
    (maddr == `PSQ_A_TBLP) ? tblp_reg :
    (maddr == `PSQ_A_TABLE_HIGH_BYTE) ? {2'h0, table_high_byte_reg} :
    (maddr == `PSQ_A_STATUS) ? {4'h0, st_reg} :
    dmem_rdata_i;

  // ****************************************
  // alu
  // ****************************************
  psq_alu_e op;
  logic [7:0] alu_r;
  logic [3:0] alu_f, alu_m;
  wire st_c = st_reg[`PSQ_F_C];
  wire [7:0] add_b = ir_reg[9] ? ~opnd_reg : opnd_reg;
  wire add_ci = ir_reg[8] ? st_c : ir_reg[9];
  wire [8:0] sum = {1'b0, acc_reg} + {1'b0, add_b} + {8'h00, add_ci};
  wire [4:0] half = {1'b0, acc_reg[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
  wire add_ov = (acc_reg[7] == add_b[7]) & (sum[7] != acc_reg[7]);
  wire daa_lo = (acc_reg[3:0] > `PSQ_BCD_MAX) | st_reg[`PSQ_F_AC];
  wire [8:0] daa_t = {1'b0, acc_reg} + {1'b0, (daa_lo ? `PSQ_DAA_LO : 8'h00)};
  wire daa_hi = (daa_t[7:4] > `PSQ_BCD_MAX) | st_c | daa_t[8];
  wire [8:0] daa_s = daa_t + (daa_hi ? `PSQ_DAA_HI : 9'h000);
  wire [7:0] sk_r = is_siz ? opnd_reg + 8'h01 : is_sdz ? opnd_reg - 8'h01 : opnd_reg;
  wire sk_zero = sk_r == 8'h00;

  assign op = psq_alu_e'(ir_reg[11:8]);

  always_comb begin
    alu_r = opnd_reg;
    alu_f = 4'h0;
    alu_m = 4'h0;
    unique case (op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        alu_r = sum[7:0];
        alu_f = {add_ov, sum[7:0] == 8'h00, half[4], sum[8]};
        alu_m = 4'hF;
      end
      ALU_AND: begin
        alu_r = acc_reg & opnd_reg;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_OR: begin
        alu_r = acc_reg | opnd_reg;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_XOR: begin
        alu_r = acc_reg ^ opnd_reg;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_CPL: begin
        alu_r = ~opnd_reg;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_RR: begin
        alu_r = {opnd_reg[0], opnd_reg[7:1]};
      end
      ALU_RRC: begin
        alu_r = {st_c, opnd_reg[7:1]};
        alu_f[`PSQ_F_C] = opnd_reg[0];
        alu_m[`PSQ_F_C] = 1'b1;
      end
      ALU_RL: begin
        alu_r = {opnd_reg[6:0], opnd_reg[7]};
      end
      ALU_RLC: begin
        alu_r = {opnd_reg[6:0], st_c};
        alu_f[`PSQ_F_C] = opnd_reg[7];
        alu_m[`PSQ_F_C] = 1'b1;
      end
      ALU_INC: begin
        alu_r = opnd_reg + 8'h01;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_DEC: begin
        alu_r = opnd_reg - 8'h01;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
      ALU_DAA: begin
        alu_r = daa_s[7:0];
        alu_f[`PSQ_F_C] = daa_hi | daa_s[8];
        alu_m[`PSQ_F_C] = 1'b1;
      end
      ALU_MOV: begin
        alu_r = opnd_reg;
        alu_f[`PSQ_F_Z] = alu_r == 8'h00;
        alu_m[`PSQ_F_Z] = 1'b1;
      end
    endcase
  end

  // result at the end of T2, committed at T4
  assign res_next = cyc_tab ? tbl_reg[7:0] :
                    is_alu ? alu_r :
                    is_movl ? maddr :
                    is_movm ? acc_reg :
                    sk_r;
  assign nfl_next = is_alu ? ((st_reg & ~alu_m) | (alu_f & alu_m)) : st_reg;
  assign skip_next = ~cyc_tab & is_skip & (is_snz ? ~sk_zero : sk_zero);

  // ****************************************
  // flow control at the T4 edge
  // ****************************************
  psq_addr_t stk_top;
  logic stk_full;
  wire pcl_w = wr_mem & (maddr == `PSQ_A_PCL);
  wire skip_hit = skip_reg;
  wire plain = ~cyc_tab & ~is_tab & ~is_br & ~is_ret & ~is_interrupt_exit & ~pcl_w & ~skip_hit;
  wire take_int = pend_reg & int_enable_i & ~insvc_reg & ~stk_full & plain;
  wire flush = take_int | is_br | is_ret | is_interrupt_exit | pcl_w | skip_hit;
  wire stk_push = at_t4 & (is_call | take_int);
  wire stk_pop = at_t4 & (is_ret | is_interrupt_exit);
  wire psq_addr_t pc_inc = pc_reg + 10'h001;

  assign pc_next = cyc_tab ? pc_inc :
                   take_int ? `PSQ_IRQ_VEC :
                   is_br ? ir_reg[9:0] :
                   (is_ret | is_interrupt_exit) ? stk_top :
                   pcl_w ? {pc_reg[9:8], res_reg} :
                   is_tab ? pc_reg :
                   pc_inc;
  // dummy cycle after any change of flow
  assign ir_next = cyc_tab ? fet_reg :
                   flush ? `PSQ_NOP :
                   is_tab ? ir_reg :
                   fet_reg;
  assign cyc_next = is_tab ? CYC_TABLE : CYC_NORMAL;
  assign tbla_next = is_tabl ? (`PSQ_LAST_PAGE | {2'h0, tblp_reg}) :
                     {pc_reg[9:8], tblp_reg};

  psq_return_stack i_psq_return_stack (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .push_i(stk_push),
    .pop_i(stk_pop),
    .push_data_i(pc_reg),
    .top_data_o(stk_top),
    .full_o(stk_full)
  );

  // ****************************************
  // phase counter and pipeline registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ph_reg <= `PSQ_PH_T1;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fet_reg <= `PSQ_NOP;
      tbl_reg <= `PSQ_NOP;
      opnd_reg <= 8'h00;
    end else if (ph_reg == `PSQ_PH_T1) begin
      if (cyc_tab) begin
        tbl_reg <= pmem_data_i;
      end else begin
        fet_reg <= pmem_data_i;
      end
      opnd_reg <= rd_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      res_reg <= 8'h00;
      nfl_reg <= 4'h0;
      skip_reg <= 1'b0;
    end else if (ph_reg == `PSQ_PH_T2) begin
      res_reg <= res_next;
      nfl_reg <= nfl_next;
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pc_reg <= `PSQ_PC_RST;
      ir_reg <= `PSQ_NOP;
      cyc_reg <= CYC_NORMAL;
      tbla_reg <= `PSQ_PC_RST;
    end else if (at_t4) begin
      pc_reg <= pc_next;
      ir_reg <= ir_next;
      cyc_reg <= cyc_next;
      tbla_reg <= tbla_next;
    end
  end

  // ****************************************
  // architectural registers
  // ****************************************
  wire wr_int = at_t4 & wr_mem;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      acc_reg <= 8'h00;
      st_reg <= 4'h0;
      tblp_reg <= 8'h00;
      table_high_byte_reg <= 6'h00;
    end else if (at_t4) begin
      if (wr_acc | (wr_int & (maddr == `PSQ_A_ACC))) begin
        acc_reg <= res_reg;
      end
      if (wr_int & (maddr == `PSQ_A_STATUS)) begin
        st_reg <= res_reg[3:0];
      end else if (~cyc_tab & is_alu) begin
        st_reg <= nfl_reg;
      end
      if (wr_int & (maddr == `PSQ_A_TBLP)) begin
        tblp_reg <= res_reg;
      end
      if (cyc_tab) begin
        table_high_byte_reg <= tbl_reg[13:8];
      end
    end
  end

  // ****************************************
  // interrupt request latch
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      insvc_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      pend_reg <= irq_i | (pend_reg & ~(at_t4 & take_int));
      ack_reg <= at_t4 & take_int;
      if (at_t4 & take_int) begin
        insvc_reg <= 1'b1;
      end else if (at_t4 & is_interrupt_exit) begin
        insvc_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pmem_addr_o = cyc_tab ? tbla_reg : pc_reg;
  assign dmem_addr_o = maddr;
  assign dmem_wdata_o = res_reg;
  assign dmem_we_o = at_t4 & wr_mem;
  assign instruction_phase_clocks_o = 4'h1 << ph_reg;
  assign int_ack_o = ack_reg;
  assign pc_o = pc_reg;
  assign acc_o = acc_reg;
  assign status_o = st_reg;
  assign table_high_byte_o = table_high_byte_reg;
  assign stack_full_o = stk_full;
endmodule

/* tb/psq_mem_model.sv */
// program and data memory standing beside the sequencer
`timescale 1ns/10ps
module psq_mem_model
  import psq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire psq_addr_t pmem_addr_i,
  output psq_word_t pmem_data_o,
  input wire logic [7:0] dmem_addr_i,
  input wire logic [7:0] dmem_wdata_i,
  input wire logic dmem_we_i,
  output logic [7:0] dmem_rdata_o
);
  psq_word_t prog_mem [0:1023];
  logic [7:0] data_mem [0:255];
  assign pmem_data_o = prog_mem[pmem_addr_i];
  assign dmem_rdata_o = data_mem[dmem_addr_i];
  always @(posedge sys_clk_i) begin
    if (dmem_we_i) begin
      data_mem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule

/* tb/psq_sequencer_props.sv */
// timing checks on the sequencer ports
`timescale 1ns/10ps
`include "psq_regs.svh"
module psq_sequencer_props
  import psq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire psq_addr_t pmem_addr_o,
  input wire logic dmem_we_o,
  input wire logic int_ack_o,
  input wire logic [3:0] instruction_phase_clocks_o,
  input wire psq_addr_t pc_o,
  input wire logic stack_full_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_phase_one_hot: assert property ($onehot(instruction_phase_clocks_o))
    else $error("phase outputs not one-hot");
  a_phase_rotates: assert property (!instruction_phase_clocks_o[3] |=>
    instruction_phase_clocks_o == ($past(instruction_phase_clocks_o) << 1))
    else $error("phase did not advance");
  a_phase_wraps: assert property (instruction_phase_clocks_o[3] |=>
    instruction_phase_clocks_o[0]) else $error("phase four not followed by one");
  a_reset_state: assert property ($past(rst_i) |->
    instruction_phase_clocks_o == 4'h1 && pc_o == `PSQ_PC_RST && !stack_full_o)
    else $error("wrong state after reset");
  a_pmem_addr_holds: assert property (!instruction_phase_clocks_o[3] |=>
    $stable(pmem_addr_o)) else $error("fetch address moved mid-cycle");
  a_pc_holds: assert property (instruction_phase_clocks_o[0] |=>
    $stable(pc_o) [*3]) else $error("pc moved outside cycle boundary");
  a_write_in_t4: assert property (dmem_we_o |-> instruction_phase_clocks_o[3])
    else $error("data write outside phase four");
  a_ack_vector: assert property (int_ack_o |-> instruction_phase_clocks_o[0] &&
    pc_o == `PSQ_IRQ_VEC && $past(instruction_phase_clocks_o[3]))
    else $error("acknowledge without vector load");
  a_ack_not_full: assert property (int_ack_o |-> !$past(stack_full_o))
    else $error("acknowledge while stack full");
  c_ack: cover property (int_ack_o);
  c_full: cover property ($rose(stack_full_o));
  c_write: cover property (dmem_we_o);
endmodule
bind psq_sequencer psq_sequencer_props i_psq_sequencer_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .pmem_addr_o(pmem_addr_o),
  .dmem_we_o(dmem_we_o),
  .int_ack_o(int_ack_o),
  .instruction_phase_clocks_o(instruction_phase_clocks_o),
  .pc_o(pc_o),
  .stack_full_o(stack_full_o)
);

/* tb/psq_sequencer_bench.sv */
// self-checking bench for the program sequencer
`timescale 1ns/10ps
module psq_sequencer_bench
  import psq_pkg::*;
;
  localparam logic [7:0] EXP [16] = '{8'h00, 8'h00, 8'h6A, 8'h69, 8'h01, 8'hFF, 8'hFE, 8'h34,
    8'hE5, 8'h65, 8'h97, 8'h96, 8'hCC, 8'hCA, 8'h35, 8'hCB};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic irq_i = 1'b0;
  logic int_enable_i = 1'b0;
  psq_addr_t pmem_addr_o;
  psq_word_t pmem_data_i;
  psq_addr_t pc_o;
  logic [7:0] dmem_addr_o;
  logic [7:0] dmem_wdata_o;
  logic [7:0] dmem_rdata_i;
  logic [7:0] acc_o;
  logic [3:0] status_o;
  logic [3:0] instruction_phase_clocks_o;
  logic [5:0] table_high_byte_o;
  logic dmem_we_o;
  logic int_ack_o;
  logic stack_full_o;
  int miscompares = 0;
  int n_tests = 0;
  int ack_cnt = 0;
  psq_sequencer i_psq_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i), .dmem_addr_o(dmem_addr_o),
    .dmem_wdata_o(dmem_wdata_o), .dmem_we_o(dmem_we_o), .dmem_rdata_i(dmem_rdata_i),
    .irq_i(irq_i), .int_enable_i(int_enable_i), .int_ack_o(int_ack_o),
    .instruction_phase_clocks_o(instruction_phase_clocks_o), .pc_o(pc_o), .acc_o(acc_o),
    .status_o(status_o), .table_high_byte_o(table_high_byte_o), .stack_full_o(stack_full_o));
  psq_mem_model i_psq_mem_model (.sys_clk_i(sys_clk_i), .pmem_addr_i(pmem_addr_o),
    .pmem_data_o(pmem_data_i), .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o),
    .dmem_we_i(dmem_we_o), .dmem_rdata_o(dmem_rdata_i));
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (int_ack_o === 1'b1) begin
      ack_cnt <= ack_cnt + 1;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task final_report;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task step(input int n);
    repeat (4 * n) @(negedge sys_clk_i);
  endtask
  task restart;
    rst_i = 1'b1;
    step(1);
    rst_i = 1'b0;
  endtask
  task clear_mem;
    for (int i = 0; i < 1024; i++) begin
      i_psq_mem_model.prog_mem[i] = 14'h0000;
    end
    for (int i = 0; i < 256; i++) begin
      i_psq_mem_model.data_mem[i] = 8'hFF;
    end
  endtask
  task wait_pc(input psq_addr_t want);
    int k;
    k = 0;
    while (pc_o !== want && k < 400) begin
      @(negedge sys_clk_i);
      k++;
    end
    check("pc reached", {6'h00, pc_o}, {6'h00, want});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_alu_ops;
    for (int i = 0; i < 16; i++) begin
      clear_mem;
      i_psq_mem_model.prog_mem[0] = 14'h0335;
      i_psq_mem_model.prog_mem[1] = {2'h1, 4'(i), 8'h20};
      i_psq_mem_model.prog_mem[2] = 14'h3002;
      i_psq_mem_model.data_mem[8'h20] = 8'hCB;
      restart;
      step(3);
      check("alu result", {8'h00, acc_o}, {8'h00, EXP[i]});
    end
  endtask
  task t_branch;
    clear_mem;
    i_psq_mem_model.prog_mem[0] = 14'h0335;
    i_psq_mem_model.prog_mem[1] = 14'h1020;
    i_psq_mem_model.prog_mem[2] = 14'h3010;
    i_psq_mem_model.prog_mem[16] = 14'h3010;
    i_psq_mem_model.data_mem[8'h20] = 8'hCB;
    restart;
    step(3);
    check("pc overlap", {6'h00, pc_o}, 16'h0003);
    check("status add", {12'h000, status_o}, 16'h0007);
    step(1);
    check("pc jump", {6'h00, pc_o}, 16'h0010);
    step(1);
    check("pc after jump", {6'h00, pc_o}, 16'h0011);
  endtask
  task t_pcl;
    clear_mem;
    i_psq_mem_model.prog_mem[0] = 14'h3150;
    i_psq_mem_model.prog_mem[336] = 14'h0320;
    i_psq_mem_model.prog_mem[337] = 14'h2006;
    restart;
    step(5);
    check("pc low write", {6'h00, pc_o}, 16'h0172);
    step(1);
    check("pc page kept", {6'h00, pc_o}, 16'h0173);
  endtask
  task t_table;
    clear_mem;
    i_psq_mem_model.prog_mem[0] = 14'h0326;
    i_psq_mem_model.prog_mem[1] = 14'h2007;
    i_psq_mem_model.prog_mem[2] = 14'h0230;
    i_psq_mem_model.prog_mem[3] = 14'h0131;
    i_psq_mem_model.prog_mem[4] = 14'h3004;
    i_psq_mem_model.prog_mem[806] = 14'h2A5C;
    i_psq_mem_model.prog_mem[38] = 14'h15A3;
    restart;
    step(5);
    check("last page high", {10'h000, table_high_byte_o}, 16'h002A);
    check("last page low", {8'h00, i_psq_mem_model.data_mem[8'h30]}, 16'h005C);
    step(1);
    check("table busy", {8'h00, i_psq_mem_model.data_mem[8'h31]}, 16'h00FF);
    step(1);
    check("page low", {8'h00, i_psq_mem_model.data_mem[8'h31]}, 16'h00A3);
    check("page high", {10'h000, table_high_byte_o}, 16'h0015);
  endtask
  task t_skip;
    clear_mem;
    i_psq_mem_model.prog_mem[0] = 14'h0840;
    i_psq_mem_model.prog_mem[1] = 14'h0311;
    i_psq_mem_model.prog_mem[2] = 14'h0322;
    i_psq_mem_model.prog_mem[3] = 14'h0641;
    i_psq_mem_model.prog_mem[4] = 14'h0333;
    i_psq_mem_model.prog_mem[5] = 14'h0742;
    i_psq_mem_model.prog_mem[6] = 14'h0344;
    i_psq_mem_model.prog_mem[7] = 14'h0543;
    i_psq_mem_model.prog_mem[8] = 14'h0355;
    i_psq_mem_model.prog_mem[9] = 14'h3009;
    i_psq_mem_model.data_mem[8'h40] = 8'h01;
    restart;
    step(3);
    check("skip dz acc", {8'h00, acc_o}, 16'h0000);
    check("skip dz mem", {8'h00, i_psq_mem_model.data_mem[8'h40]}, 16'h0000);
    step(5);
    check("skip nz iz acc", {8'h00, acc_o}, 16'h0022);
    check("skip iz mem", {8'h00, i_psq_mem_model.data_mem[8'h42]}, 16'h0000);
    step(2);
    check("no skip acc", {8'h00, acc_o}, 16'h0055);
  endtask
  task t_stack;
    int k;
    int base;
    clear_mem;
    i_psq_mem_model.prog_mem[0] = 14'h3440;
    i_psq_mem_model.prog_mem[64] = 14'h3480;
    i_psq_mem_model.prog_mem[128] = 14'h34C0;
    i_psq_mem_model.prog_mem[192] = 14'h3500;
    i_psq_mem_model.prog_mem[256] = 14'h3540;
    i_psq_mem_model.prog_mem[320] = 14'h0001;
    i_psq_mem_model.prog_mem[4] = 14'h0002;
    int_enable_i = 1'b1;
    restart;
    base = ack_cnt;
    wait_pc(10'h140);
    check("stack full", {15'h0000, stack_full_o}, 16'h0001);
    irq_i = 1'b1;
    @(negedge sys_clk_i);
    irq_i = 1'b0;
    wait_pc(10'h101);
    check("ack held", 16'(ack_cnt - base), 16'h0000);
    k = 0;
    while (ack_cnt == base && k < 60) begin
      @(negedge sys_clk_i);
      k++;
    end
    check("ack after pop", 16'(ack_cnt - base), 16'h0001);
    step(6);
    check("return page", {9'h000, pc_o[9:3]}, 16'h0020);
    int_enable_i = 1'b0;
  endtask
  initial begin
    #64000;
    miscompares++;
    final_report;
  end
  initial begin
    t_alu_ops;
    t_branch;
    t_pcl;
    t_table;
    t_skip;
    t_stack;
    final_report;
  end
endmodule
